//--- logic/tsc_defs.svh
// Register indices, field positions, reset values and timing counts of the timer
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
// ****************************************
// Register indices (byte address is index times four)
// ****************************************
`define TSC_IDX_COUNT 10'h322
`define TSC_IDX_PERIOD 10'h323
`define TSC_IDX_CONTROL 10'h324
`define TSC_IDX_HLT 10'h325
`define TSC_IDX_CLKCON 10'h326
`define TSC_IDX_RSTSEL 10'h327
`define TSC_IDX_STATUS 10'h328
// ****************************************
// Field positions
// ****************************************
`define TSC_ON_BIT 7
`define TSC_PRESCALER_SYNC_ENABLE_BIT 7
`define TSC_CPOL_BIT 6
`define TSC_ON_SYNC_ENABLE_BIT 5
// ****************************************
// Reset values
// ****************************************
`define TSC_COUNT_RST 8'h00
`define TSC_PERIOD_RST 8'hff
`define TSC_CONTROL_RST 8'h00
`define TSC_HLT_RST 8'h00
`define TSC_CLKCON_RST 5'h00
`define TSC_RSTSEL_RST 6'h00
// ****************************************
// Source codes and masks
// ****************************************
`define TSC_CS_RSVD 5'h16
`define TSC_RSEL_RSVD 6'h24
`define TSC_CLK_VALID 22'h3ffff9
`define TSC_RST_VALID 36'hfffff9fff
// ****************************************
// Timing counts
// ****************************************
`define TSC_INSTR_LAST 2'h3
`endif

//--- logic/tsc_pkg.sv
// Types shared by the timer source and synchronisation block
package tsc_pkg;
  typedef enum logic [4:0] {
    TSC_CS_PIN = 5'b00000,
    TSC_CS_INSTR = 5'b00001,
    TSC_CS_SYS = 5'b00010
  } tsc_cs_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tsc_apb_rsp_t;

  typedef struct packed {
    logic [21:0] cs_sync1;
    logic [21:0] cs_sync2;
    logic [35:0] rs_sync1;
    logic [35:0] rs_sync2;
    logic [1:0] div;
    logic instr_tick;
    logic tclk;
    logic tick_pend;
    logic [1:0] on_sh;
    logic run;
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] control;
    logic [7:0] hlt;
    logic [4:0] clkcon;
    logic [5:0] rstsel;
    logic xrst;
    logic match;
    tsc_apb_rsp_t rsp;
  } tsc_state_t;
endpackage

//--- logic/tsc_top.sv
// Timer clock/reset source selection, enable synchronisation and 8-bit period counter
//
// Summary of operation
// R1: Sync bit routes enable through timer-clock synchroniser
// R2: Synchronised enable switches without glitches
// R3: Synchronised start waits two timer clock edges
// R4: Prescaler sync keeps count reads coherent
// R5: Prescaler sync stops counting during sleep
// R6: Software changes polarity only while off
// R7: Enable starts counting, clearing it stops
// R8: Stopping freezes the count unchanged
// R9: Count equal to period clears next tick
// R10: Five-bit mode field accepts every code
// R11: Clock codes 0-7 select pin, clocks, oscillators
// R12: Clock codes 8-21 select peripherals, rest reserved
// R13: Reset codes 4-12 and 15-35 select peripherals, rest reserved
// R14: Reset code 0 pin, 1-3 sibling postscalers
// R15: Prescaler sync aligns ticks to instruction clock
// R16: Reserved source codes stay inactive
//
// The APB interface to the registers was chosen for this implementation.
`include "tsc_defs.svh"

module tsc_top #(
  parameter int OWN_SLOT = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire tsc_pkg::tsc_apb_req_t apb_req,
  output tsc_pkg::tsc_apb_rsp_t apb_rsp,
  // Sources indexed by selection code, and sleep input
  input wire logic [21:0] clk_src,
  input wire logic [35:0] rst_src,
  input wire logic sleep_mode,
  // Timer outputs
  output logic period_match,
  output logic timer_run,
  output logic ext_reset
);
  import tsc_pkg::*;

  tsc_state_t st;
  tsc_state_t next_st;
  logic [31:0] cs_all;
  logic [63:0] rs_all;
  logic [35:0] rst_valid;
  logic src_tick;
  logic cnt_tick;
  logic lvl;
  logic access;
  logic hit;
  logic wr_en;
  logic [9:0] idx;
  logic [7:0] rd_val;
  logic prescaler_sync_enable;
  logic on_sync_enable;

  // ****************************************
  // Source masks
  // ****************************************
  always_comb begin
    rst_valid = `TSC_RST_VALID;
    rst_valid[OWN_SLOT] = 1'b0; // see R14
  end

  assign prescaler_sync_enable = st.hlt[`TSC_PRESCALER_SYNC_ENABLE_BIT];
  assign on_sync_enable = st.hlt[`TSC_ON_SYNC_ENABLE_BIT];
  assign cs_all = {10'h000, st.cs_sync2 & `TSC_CLK_VALID}; // see R16
  assign rs_all = {28'h0000000, st.rs_sync2 & rst_valid}; // see R16
  assign access = apb_req.psel & apb_req.penable;
  assign idx = apb_req.paddr[11:2];
  assign hit = (idx >= `TSC_IDX_COUNT) && (idx <= `TSC_IDX_STATUS);
  assign wr_en = access & st.rsp.pready & apb_req.pwrite & ~st.rsp.pslverr;

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    case (idx)
      `TSC_IDX_COUNT: rd_val = st.count;
      `TSC_IDX_PERIOD: rd_val = st.period;
      `TSC_IDX_CONTROL: rd_val = st.control;
      `TSC_IDX_HLT: rd_val = st.hlt;
      `TSC_IDX_CLKCON: rd_val = {3'h0, st.clkcon};
      `TSC_IDX_RSTSEL: rd_val = {2'h0, st.rstsel};
      `TSC_IDX_STATUS: rd_val = {5'h00, st.xrst, st.tclk, st.run};
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.cs_sync1 = clk_src;
    next_st.cs_sync2 = st.cs_sync1;
    next_st.rs_sync1 = rst_src;
    next_st.rs_sync2 = st.rs_sync1;
    next_st.div = st.div + 2'h1;
    next_st.instr_tick = (st.div == `TSC_INSTR_LAST);
    lvl = 1'b0;
    // Timer clock selection
    case (st.clkcon)
      TSC_CS_INSTR: src_tick = st.instr_tick; // see R11
      TSC_CS_SYS: src_tick = 1'b1; // see R11
      default: begin
        if (st.clkcon < `TSC_CS_RSVD) begin
          lvl = cs_all[st.clkcon] ^ st.hlt[`TSC_CPOL_BIT]; // see R11, R12
        end
        src_tick = lvl & ~st.tclk; // see R16
      end
    endcase
    next_st.tclk = lvl;
    // Enable synchroniser on timer clock edges
    if (src_tick) begin
      next_st.on_sh = {st.on_sh[0], st.control[`TSC_ON_BIT]}; // see R1, R3
    end
    next_st.run = on_sync_enable ? st.on_sh[1] : st.control[`TSC_ON_BIT]; // see R1, R2, R7
    // Prescaler sync to instruction clock
    if (prescaler_sync_enable) begin
      cnt_tick = (st.tick_pend | src_tick) & st.instr_tick & ~sleep_mode; // see R5, R15
    end else begin
      cnt_tick = src_tick;
    end
    next_st.tick_pend = prescaler_sync_enable & (st.tick_pend | src_tick) & ~cnt_tick; // see R15
    // Counter
    next_st.match = 1'b0;
    if (st.run && cnt_tick) begin // see R7, R8
      if (st.count == st.period) begin
        next_st.count = 8'h00; // see R9
        next_st.match = 1'b1;
      end else begin
        next_st.count = st.count + 8'h01;
      end
    end
    // External reset selection
    next_st.xrst = (st.rstsel < `TSC_RSEL_RSVD) ? rs_all[st.rstsel] : 1'b0; // see R13, R14
    // APB slave, one wait state
    if (access && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = ~hit;
      next_st.rsp.prdata = {24'h000000, rd_val}; // see R4
    end else begin
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
    end
    if (wr_en) begin
      case (idx)
        `TSC_IDX_COUNT: next_st.count = apb_req.pwdata[7:0];
        `TSC_IDX_PERIOD: next_st.period = apb_req.pwdata[7:0];
        `TSC_IDX_CONTROL: next_st.control = apb_req.pwdata[7:0];
        `TSC_IDX_HLT: next_st.hlt = apb_req.pwdata[7:0]; // see R10
        `TSC_IDX_CLKCON: next_st.clkcon = apb_req.pwdata[4:0];
        `TSC_IDX_RSTSEL: next_st.rstsel = apb_req.pwdata[5:0];
        default: next_st.count = next_st.count;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.period <= `TSC_PERIOD_RST;
      st.count <= `TSC_COUNT_RST;
      st.control <= `TSC_CONTROL_RST;
      st.hlt <= `TSC_HLT_RST;
      st.clkcon <= `TSC_CLKCON_RST;
      st.rstsel <= `TSC_RSTSEL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign period_match = st.match;
  assign timer_run = st.run;
  assign ext_reset = st.xrst;

  // ****************************************
  // Assertions
  // ****************************************
  logic wr_count;
  assign wr_count = wr_en && (idx == `TSC_IDX_COUNT);

  property p_sync_delay;
    @(posedge sys_clk) disable iff (reset)
    (on_sync_enable && $rose(st.control[`TSC_ON_BIT]) && !st.run && st.on_sh == 2'b00)
      |-> !st.run [*2];
  endproperty
  a_sync_delay: assert property (p_sync_delay) // see R3
    else $error("Synchronised start came before two timer clock edges");

  property p_sync_path;
    @(posedge sys_clk) disable iff (reset)
    on_sync_enable |=> (st.run == $past(st.on_sh[1]));
  endproperty
  a_sync_path: assert property (p_sync_path) // see R1
    else $error("Run did not follow the synchronised enable");

  property p_direct_stop;
    @(posedge sys_clk) disable iff (reset)
    (!on_sync_enable && $fell(st.control[`TSC_ON_BIT]))
      |=> !st.run ##1 ($stable(st.count) || $past(wr_count));
  endproperty
  a_direct_stop: assert property (p_direct_stop) // see R7
    else $error("Unsynchronised stop did not take effect at once");

  property p_freeze;
    @(posedge sys_clk) disable iff (reset)
    (!st.run && !wr_count) |=> $stable(st.count);
  endproperty
  a_freeze: assert property (p_freeze) // see R8
    else $error("Count moved while stopped");

  property p_wrap;
    @(posedge sys_clk) disable iff (reset)
    (st.run && cnt_tick && st.count == st.period && !wr_count)
      |=> (st.count == 8'h00) && st.match;
  endproperty
  a_wrap: assert property (p_wrap) // see R9
    else $error("Count did not clear after period match");

  property p_sleep;
    @(posedge sys_clk) disable iff (reset)
    (prescaler_sync_enable && sleep_mode && !wr_count) |=> $stable(st.count);
  endproperty
  a_sleep: assert property (p_sleep) // see R5
    else $error("Count moved in sleep with prescaler sync");

  property p_prescaler_sync_enable_align;
    @(posedge sys_clk) disable iff (reset)
    (prescaler_sync_enable && !st.instr_tick && !wr_count) |=> $stable(st.count);
  endproperty
  a_prescaler_sync_enable_align: assert property (p_prescaler_sync_enable_align) // see R15
    else $error("Count moved off the instruction clock");

  property p_rsvd_clk;
    @(posedge sys_clk) disable iff (reset)
    (st.clkcon >= `TSC_CS_RSVD) [*2] |-> !st.tclk;
  endproperty
  a_rsvd_clk: assert property (p_rsvd_clk) // see R16
    else $error("Reserved clock code drove the timer clock");

  property p_rsvd_rst;
    @(posedge sys_clk) disable iff (reset)
    ((st.rstsel >= `TSC_RSEL_RSVD) || (st.rstsel == 6'(OWN_SLOT))) |=> !st.xrst;
  endproperty
  a_rsvd_rst: assert property (p_rsvd_rst) // see R14
    else $error("Reserved reset code drove the external reset");

  property p_mode_write;
    @(posedge sys_clk) disable iff (reset)
    (wr_en && idx == `TSC_IDX_HLT) |=> (st.hlt[4:0] == $past(apb_req.pwdata[4:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) // see R10
    else $error("Mode field did not take the written code");

  property p_read_data;
    @(posedge sys_clk) disable iff (reset)
    (access && !st.rsp.pready && !apb_req.pwrite && idx == `TSC_IDX_COUNT)
      |=> (st.rsp.prdata == {24'h000000, $past(st.count)});
  endproperty
  a_read_data: assert property (p_read_data) // see R4
    else $error("Count read did not return the registered count");

  property p_direct_start;
    @(posedge sys_clk) disable iff (reset)
    (!on_sync_enable && $rose(st.control[`TSC_ON_BIT])) |=> st.run;
  endproperty
  a_direct_start: assert property (p_direct_start) // see R7
    else $error("Unsynchronised start did not take effect");

  property p_run_off;
    @(posedge sys_clk) disable iff (reset)
    (!on_sync_enable && !st.control[`TSC_ON_BIT]) |=> !st.run;
  endproperty
  a_run_off: assert property (p_run_off) // see R7
    else $error("Run stayed high with enable clear");

  property p_sync_stop;
    @(posedge sys_clk) disable iff (reset)
    (on_sync_enable && st.on_sh == 2'b00) |=> !st.run;
  endproperty
  a_sync_stop: assert property (p_sync_stop) // see R2
    else $error("Run rose without a synchronised enable");

  property p_sync_hold;
    @(posedge sys_clk) disable iff (reset)
    !src_tick |=> $stable(st.on_sh);
  endproperty
  a_sync_hold: assert property (p_sync_hold) // see R2
    else $error("Enable synchroniser moved without a timer clock edge");

  property p_sys_tick;
    @(posedge sys_clk) disable iff (reset)
    (st.clkcon == 5'h02 && !prescaler_sync_enable && st.run && !wr_count && st.count != st.period)
      |=> (st.count == $past(st.count) + 8'h01);
  endproperty
  a_sys_tick: assert property (p_sys_tick) // see R11
    else $error("System clock source did not count every cycle");

  property p_instr_tick;
    @(posedge sys_clk) disable iff (reset)
    (st.clkcon == 5'h01) |-> (src_tick == st.instr_tick);
  endproperty
  a_instr_tick: assert property (p_instr_tick) // see R11
    else $error("Instruction clock source ticked off its slot");

  property p_no_match;
    @(posedge sys_clk) disable iff (reset)
    (st.run && cnt_tick && st.count != st.period) |=> !st.match;
  endproperty
  a_no_match: assert property (p_no_match) // see R9
    else $error("Match pulse without period match");

  property p_rsvd_tick;
    @(posedge sys_clk) disable iff (reset)
    (st.clkcon >= `TSC_CS_RSVD) |-> !src_tick;
  endproperty
  a_rsvd_tick: assert property (p_rsvd_tick) // see R16
    else $error("Reserved clock code produced a tick");

  property p_xrst_ccp;
    @(posedge sys_clk) disable iff (reset)
    (st.rstsel == 6'h04) |=> (st.xrst == $past(st.rs_sync2[4]));
  endproperty
  a_xrst_ccp: assert property (p_xrst_ccp) // see R13
    else $error("Reset code 4 did not follow its source");

  property p_xrst_pin;
    @(posedge sys_clk) disable iff (reset)
    (st.rstsel == 6'h00) |=> (st.xrst == $past(st.rs_sync2[0]));
  endproperty
  a_xrst_pin: assert property (p_xrst_pin) // see R14
    else $error("Reset code 0 did not follow the pin");

  property p_rsel_gap;
    @(posedge sys_clk) disable iff (reset)
    (st.rstsel == 6'h0d || st.rstsel == 6'h0e) |=> !st.xrst;
  endproperty
  a_rsel_gap: assert property (p_rsel_gap) // see R13
    else $error("Reserved reset gap drove the external reset");
endmodule

//--- tb/tb.sv
// Self-checking bench for the timer source and synchronisation block
`include "tsc_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [9:0] idx;
    logic [7:0] d;
    logic [7:0] exp;
    logic err;
  } tsc_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic sleep_mode = 1'b0;
  tsc_apb_req_t req = '0;
  tsc_apb_rsp_t rsp;
  logic [21:0] clk_src;
  logic [35:0] rst_src;
  logic period_match, timer_run, ext_reset;
  int n_fail = 0;
  int n_tests = 0;
  logic [31:0] rd, rd2;
  logic err;
  int k;
  tsc_row_t rows [0:11] = '{
    '{1'b0, `TSC_IDX_COUNT, 8'h00, `TSC_COUNT_RST, 1'b0},
    '{1'b0, `TSC_IDX_PERIOD, 8'h00, `TSC_PERIOD_RST, 1'b0},
    '{1'b0, `TSC_IDX_CONTROL, 8'h00, `TSC_CONTROL_RST, 1'b0},
    '{1'b0, `TSC_IDX_HLT, 8'h00, `TSC_HLT_RST, 1'b0},
    '{1'b0, `TSC_IDX_CLKCON, 8'h00, 8'h00, 1'b0},
    '{1'b0, `TSC_IDX_RSTSEL, 8'h00, 8'h00, 1'b0},
    '{1'b1, `TSC_IDX_PERIOD, 8'ha5, 8'ha5, 1'b0},
    '{1'b1, `TSC_IDX_COUNT, 8'h3c, 8'h3c, 1'b0},
    '{1'b1, `TSC_IDX_CONTROL, 8'h7f, 8'h7f, 1'b0},
    '{1'b1, `TSC_IDX_CLKCON, 8'hff, 8'h1f, 1'b0},
    '{1'b1, `TSC_IDX_RSTSEL, 8'hff, 8'h3f, 1'b0},
    '{1'b1, 10'h329, 8'h55, 8'h00, 1'b1}};

  always #25 sys_clk = ~sys_clk;

  tsc_top #(.OWN_SLOT(1)) i_tsc_top (.sys_clk(sys_clk), .reset(reset), .apb_req(req),
    .apb_rsp(rsp), .clk_src(clk_src), .rst_src(rst_src), .sleep_mode(sleep_mode),
    .period_match(period_match), .timer_run(timer_run), .ext_reset(ext_reset));
  tsc_src_model i_tsc_src_model (.sys_clk(sys_clk), .reset(reset),
    .rst_level(36'hfffffffff), .clk_src(clk_src), .rst_src(rst_src));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int w;
    w = 0;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, d}};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      w++;
    end while (rsp.pready !== 1'b1 && w < 20);
    if (rsp.pready !== 1'b1) n_fail++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("tests %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].d);
      apb(1'b0, rows[i].idx, 8'h00);
      chk("read data", {24'h0, rows[i].exp}, rd);
      chk("error flag", {31'h0, rows[i].err}, {31'h0, err});
    end
    $display("test register table done");
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, `TSC_IDX_HLT, 8'(c));
      apb(1'b0, `TSC_IDX_HLT, 8'h00);
      chk("mode field", 32'(c), rd);
    end
    for (int c = 0; c < 64; c++) begin
      apb(1'b1, `TSC_IDX_RSTSEL, 8'(c));
      repeat (6) @(posedge sys_clk);
      chk("ext reset", 32'(c < 36 && c != 1 && c != 13 && c != 14), 32'(ext_reset));
    end
    $display("test source codes done");
    apb(1'b1, `TSC_IDX_HLT, 8'h00);
    apb(1'b1, `TSC_IDX_PERIOD, 8'hff);
    apb(1'b1, `TSC_IDX_CONTROL, 8'h80);
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, `TSC_IDX_CLKCON, 8'(c));
      apb(1'b1, `TSC_IDX_COUNT, 8'h00);
      repeat (40) @(posedge sys_clk);
      apb(1'b0, `TSC_IDX_COUNT, 8'h00);
      chk("count moved", 32'(c < 22), 32'(rd != 0));
    end
    $display("test clock codes done");
    apb(1'b1, `TSC_IDX_CONTROL, 8'h00);
    apb(1'b1, `TSC_IDX_CLKCON, 8'h02);
    apb(1'b1, `TSC_IDX_PERIOD, 8'h03);
    apb(1'b1, `TSC_IDX_COUNT, 8'h00);
    apb(1'b1, `TSC_IDX_CONTROL, 8'h80);
    k = 0;
    while (period_match !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (period_match !== 1'b1 && k < 50);
    chk("wrap spacing", 32'd4, 32'(k));
    apb(1'b1, `TSC_IDX_CONTROL, 8'h00);
    apb(1'b0, `TSC_IDX_COUNT, 8'h00);
    rd2 = rd;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, `TSC_IDX_COUNT, 8'h00);
    chk("frozen count", rd2, rd);
    chk("run off", 32'h0, 32'(timer_run));
    $display("test period and stop done");
    apb(1'b1, `TSC_IDX_HLT, 8'h20);
    apb(1'b1, `TSC_IDX_CLKCON, 8'h00);
    apb(1'b1, `TSC_IDX_CONTROL, 8'h80);
    repeat (3) @(posedge sys_clk);
    chk("sync run early", 32'h0, 32'(timer_run));
    k = 0;
    while (timer_run !== 1'b1 && k < 60) begin
      @(posedge sys_clk);
      k++;
    end
    chk("sync run late", 32'h1, 32'(timer_run));
    apb(1'b1, `TSC_IDX_CONTROL, 8'h00);
    apb(1'b1, `TSC_IDX_HLT, 8'h00);
    apb(1'b1, `TSC_IDX_CLKCON, 8'h02);
    apb(1'b1, `TSC_IDX_CONTROL, 8'h80);
    repeat (3) @(posedge sys_clk);
    chk("direct run", 32'h1, 32'(timer_run));
    $display("test on sync done");
    apb(1'b1, `TSC_IDX_CONTROL, 8'h00);
    apb(1'b1, `TSC_IDX_HLT, 8'h80);
    apb(1'b1, `TSC_IDX_PERIOD, 8'hff);
    apb(1'b1, `TSC_IDX_COUNT, 8'h00);
    sleep_mode <= 1'b1;
    apb(1'b1, `TSC_IDX_CONTROL, 8'h80);
    repeat (30) @(posedge sys_clk);
    apb(1'b0, `TSC_IDX_COUNT, 8'h00);
    chk("sleep count", 32'h0, rd);
    sleep_mode <= 1'b0;
    repeat (30) @(posedge sys_clk);
    apb(1'b0, `TSC_IDX_COUNT, 8'h00);
    chk("awake count", 32'h1, 32'(rd != 0));
    $display("test sleep done");
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    chk("reset run", 32'h0, 32'(timer_run));
    apb(1'b0, `TSC_IDX_COUNT, 8'h00);
    chk("reset count", {24'h0, `TSC_COUNT_RST}, rd);
    $display("test reset done");
    summarize();
  end
endmodule

//--- tb/tsc_src_model.sv
// Model of the on-chip clock and reset sources feeding the timer
module tsc_src_model #(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Reset source levels set by the bench
  input wire logic [35:0] rst_level,
  // Source lines
  output logic [21:0] clk_src,
  output logic [35:0] rst_src
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  logic tclk;
  // Free running source clock, HALF sys_clk cycles per half period
  always_ff @(posedge sys_clk) begin
    if (reset || cnt == 8'(HALF - 1)) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
    if (reset) begin
      tclk <= 1'b0;
    end else if (cnt == 8'(HALF - 1)) begin
      tclk <= ~tclk;
    end
  end
  assign clk_src = {22{tclk}};
  assign rst_src = rst_level;
endmodule
